// [src/nsl_params.svh]
// constants for the network status lamp sequencer
// assumes a single 20 MHz core clock and a plain register port
`ifndef NSL_PARAMS_SVH
`define NSL_PARAMS_SVH

// clock and timing, times in ms
`define NSL_CLK_HZ 20000000
`define NSL_TICK_MS 1
`define NSL_TICK_CYCLES (`NSL_CLK_HZ / 1000 * `NSL_TICK_MS)
`define NSL_FLASH_MS 500
`define NSL_STEST_MS 250
`define NSL_STEST_OFF_MS 250

// register offsets (byte addresses)
`define NSL_REG_CTRL 4'h0
`define NSL_REG_STAT 4'h4
`define NSL_REG_COND 4'h8

// control register
`define NSL_CTRL_MASTER_BIT 0
`define NSL_CTRL_RST 1'h1

// status register fields
`define NSL_STAT_PAT_LSB 0
`define NSL_STAT_PHASE_LSB 8
`define NSL_STAT_GREEN_BIT 12
`define NSL_STAT_RED_BIT 13

`endif

// [src/nsl_pkg.sv]
// types for the network status lamp sequencer
// assumes nsl_params.svh supplies the timing and register constants; pattern codes are set here
package nsl_pkg;

  // status conditions from the protocol engine
  typedef struct packed {
    logic self_test;
    logic dup_check_done;
    logic dup_addr_found;
    logic bus_off;
    logic net_power;
    logic conn_any;
    logic conn_all;
    logic minor_fault;
    logic conn_timeout;
  } nsl_cond_t;

  // lamp drive pair
  typedef struct packed {
    logic green;
    logic red;
  } nsl_lamp_t;

  // selected light pattern
  typedef enum logic [5:0] {
    PAT_DARK   = 6'h01,
    PAT_GRN_ON = 6'h02,
    PAT_GRN_FL = 6'h04,
    PAT_RED_FL = 6'h08,
    PAT_RED_ON = 6'h10,
    PAT_STEST  = 6'h20
  } nsl_pat_t;

endpackage : nsl_pkg

// [src/nsl_status_led.sv]
// module network status lamp sequencer: condition inputs to red/green drive
// assumes conditions are synchronous to core_clk and held as levels
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "nsl_params.svh"

// Functional notes
// - steady green when online and all configured connections established.
// - master: green 1 Hz flash when online with no established connection.
// - green, red, off pattern while power-on self test runs.
// - master: red 1 Hz flash on minor fault or lost remote node.
// - master: red flash when some connections exchange but others are missing.
// - slave: red flash on no connection, no exchange, timeout or no power.
// - steady red on duplicate node address or bus-off.
// - both dark when not online: check pending, or network power missing on a master.
// - each 1 Hz flash is 500 ms lit then 500 ms dark, repeating.
// - self test lights green 250 ms, red 250 ms, dark 250 ms, repeating while held.
module nsl_status_led #(
  parameter int TICK_CYCLES = `NSL_TICK_CYCLES,
  parameter int PRE_W = 15,
  parameter int MS_W = 10,
  parameter int FLASH_MS = `NSL_FLASH_MS,
  parameter int STEST_MS = `NSL_STEST_MS,
  parameter int STEST_OFF_MS = `NSL_STEST_OFF_MS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // protocol engine status
  input nsl_pkg::nsl_cond_t cond,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // lamp drives
  output logic led_green,
  output logic led_red
);

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam logic [MS_W-1:0] FLASH_LAST = MS_W'(FLASH_MS - 1);
  localparam logic [MS_W-1:0] STEST_LAST = MS_W'(STEST_MS - 1);
  localparam logic [MS_W-1:0] STOFF_LAST = MS_W'(STEST_OFF_MS - 1);

  // control register
  logic ctrl_master_r;
  logic ctrl_master_nxt;

  // sequencer state
  nsl_pkg::nsl_pat_t pat_r;
  nsl_pkg::nsl_pat_t pat_nxt;
  nsl_pkg::nsl_pat_t pat_sel;
  logic pat_change;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic ms_tick;
  logic [MS_W-1:0] ms_r;
  logic [MS_W-1:0] ms_nxt;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  // output flops
  logic led_green_r;
  logic led_red_r;
  logic [31:0] rdata_r;
  nsl_pkg::nsl_lamp_t lamp_nxt;
  logic [31:0] rdata_nxt;

  // decoded conditions, one per candidate pattern
  logic online;
  logic red_flash_m;
  logic red_flash_s;
  logic want_stest;
  logic want_red_on;
  logic want_red_fl;
  logic want_grn_fl;
  logic want_grn_on;

  // last ms of a phase for the given pattern
  function automatic logic [MS_W-1:0] phase_last(
    input nsl_pkg::nsl_pat_t pat,
    input logic [1:0] phase
  );
    logic [MS_W-1:0] last;
    last = FLASH_LAST;
    if (pat == nsl_pkg::PAT_STEST) begin
      last = (phase == 2'h2) ? STOFF_LAST : STEST_LAST;
    end
    return last;
  endfunction : phase_last

  // phase that follows the given one
  function automatic logic [1:0] phase_step(
    input nsl_pkg::nsl_pat_t pat,
    input logic [1:0] phase
  );
    logic [1:0] step;
    step = 2'h0;
    if (pat == nsl_pkg::PAT_STEST) begin
      step = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    end else begin
      step = {1'b0, ~phase[0]};
    end
    return step;
  endfunction : phase_step

  // lamp drive for a pattern and phase
  function automatic nsl_pkg::nsl_lamp_t lamp_of(
    input nsl_pkg::nsl_pat_t pat,
    input logic [1:0] phase
  );
    nsl_pkg::nsl_lamp_t l;
    l = '0;
    unique case (pat)
      nsl_pkg::PAT_DARK: begin
        l = '0;
      end
      nsl_pkg::PAT_GRN_ON: begin
        l.green = 1'b1;
      end
      nsl_pkg::PAT_GRN_FL: begin
        l.green = (phase == 2'h0);
      end
      nsl_pkg::PAT_RED_FL: begin
        l.red = (phase == 2'h0);
      end
      nsl_pkg::PAT_RED_ON: begin
        l.red = 1'b1;
      end
      nsl_pkg::PAT_STEST: begin
        l.green = (phase == 2'h0);
        l.red = (phase == 2'h1);
      end
      default: begin
        l = '0;
      end
    endcase
    return l;
  endfunction : lamp_of

  // condition decode and pattern selection
  always_comb begin
    online = cond.dup_check_done & cond.net_power;
    // master: any lost exchange, timeout or partially connected set
    red_flash_m = online & (cond.minor_fault | cond.conn_timeout
                  | (cond.conn_any & ~cond.conn_all));
    // slave flags missing power too, so it outranks the dark case
    red_flash_s = cond.dup_check_done & (~cond.conn_any | cond.minor_fault
                  | cond.conn_timeout | ~cond.net_power);
    want_stest = cond.self_test;
    want_red_on = cond.dup_addr_found | cond.bus_off;
    want_red_fl = ctrl_master_r ? red_flash_m : red_flash_s;
    want_grn_fl = online & ~cond.conn_any;
    want_grn_on = online & cond.conn_all;
    // first match wins, so overlapping conditions never mix colours
    if (want_stest) begin
      pat_sel = nsl_pkg::PAT_STEST;
    end else if (want_red_on) begin
      pat_sel = nsl_pkg::PAT_RED_ON;
    end else if (want_red_fl) begin
      pat_sel = nsl_pkg::PAT_RED_FL;
    end else if (want_grn_fl) begin
      pat_sel = nsl_pkg::PAT_GRN_FL;
    end else if (want_grn_on) begin
      pat_sel = nsl_pkg::PAT_GRN_ON;
    end else begin
      pat_sel = nsl_pkg::PAT_DARK;
    end
  end

  // pattern register; any change restarts the timers below
  // a one-cycle condition glitch also restarts the flash, a known limitation
  always_comb begin
    pat_nxt = pat_sel;
    pat_change = (pat_sel != pat_r);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pat_r <= nsl_pkg::PAT_DARK;
    end else begin
      pat_r <= pat_nxt;
    end
  end

  // millisecond divider; an enable tick keeps all state on core_clk
  always_comb begin
    ms_tick = 1'b0;
    pre_nxt = pre_r + PRE_W'(1);
    if (pat_change) begin
      // realigned so the first lit phase is a whole number of ms
      pre_nxt = '0;
    end else if (pre_r == PRE_LAST) begin
      pre_nxt = '0;
      ms_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // phase timer counts whole ms inside the current phase
  always_comb begin
    ms_nxt = ms_r;
    phase_nxt = phase_r;
    if (pat_change) begin
      // fresh pattern always opens on its lit phase
      ms_nxt = '0;
      phase_nxt = 2'h0;
    end else if (ms_tick) begin
      if (ms_r == phase_last(pat_r, phase_r)) begin
        ms_nxt = '0;
        phase_nxt = phase_step(pat_r, phase_r);
      end else begin
        ms_nxt = ms_r + MS_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ms_r <= '0;
      phase_r <= 2'h0;
    end else begin
      ms_r <= ms_nxt;
      phase_r <= phase_nxt;
    end
  end

  // drive worked out from next state so it lines up with phase_r
  always_comb begin
    lamp_nxt = lamp_of(pat_nxt, phase_nxt);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      led_green_r <= 1'b0;
      led_red_r <= 1'b0;
    end else begin
      led_green_r <= lamp_nxt.green;
      led_red_r <= lamp_nxt.red;
    end
  end

  // role register; writes to other offsets are dropped
  always_comb begin
    ctrl_master_nxt = ctrl_master_r;
    if (reg_wr && reg_addr == `NSL_REG_CTRL) begin
      ctrl_master_nxt = reg_wdata[`NSL_CTRL_MASTER_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_master_r <= `NSL_CTRL_RST;
    end else begin
      ctrl_master_r <= ctrl_master_nxt;
    end
  end

  // read port; data stand for one cycle only, zero otherwise
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `NSL_REG_CTRL: begin
          rdata_nxt[`NSL_CTRL_MASTER_BIT] = ctrl_master_r;
        end
        `NSL_REG_STAT: begin
          rdata_nxt[`NSL_STAT_PAT_LSB +: 6] = pat_r;
          rdata_nxt[`NSL_STAT_PHASE_LSB +: 2] = phase_r;
          rdata_nxt[`NSL_STAT_GREEN_BIT] = led_green_r;
          rdata_nxt[`NSL_STAT_RED_BIT] = led_red_r;
        end
        `NSL_REG_COND: begin
          rdata_nxt[8:0] = cond;
        end
        default: begin
          rdata_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign led_green = led_green_r;
  assign led_red = led_red_r;

endmodule : nsl_status_led

// [verification/nsl_lamp_model.sv]
// bicolour lamp model: turns the two drives into a seen colour
// assumes active high drive levels
`timescale 1ns/1ps
module nsl_lamp_model (
  // drives from the sequencer
  input wire logic green,
  input wire logic red,
  // seen colour: 0 dark, 1 red, 2 green, 3 both
  output logic [1:0] shade
);
  assign shade = {green, red};
endmodule : nsl_lamp_model

// [verification/nsl_status_led_assertions.sv]
// port checker for the lamp sequencer
// assumes binding to nsl_status_led, one clock domain
`timescale 1ns/1ps
module nsl_status_led_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // observed ports
  input nsl_pkg::nsl_cond_t cond,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic led_green,
  input wire logic led_red
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic hi;
  logic onl;
  assign hi = cond.self_test | cond.dup_addr_found | cond.bus_off;
  assign onl = cond.dup_check_done & cond.net_power;
  property p_rst; $fell(sys_rst) |-> !led_green && !led_red; endproperty
  a_rst: assert property (p_rst) else $error("lamp lit after reset");
  property p_red_on; !cond.self_test && (cond.dup_addr_found || cond.bus_off) |=> led_red && !led_green; endproperty
  a_red_on: assert property (p_red_on) else $error("red not steady");
  property p_dark; !hi && !cond.dup_check_done |=> !led_green && !led_red; endproperty
  a_dark: assert property (p_dark) else $error("lamp lit while offline");
  property p_both; !(led_green && led_red); endproperty
  a_both: assert property (p_both) else $error("both elements lit");
  property p_grn; !hi && onl && cond.conn_any && cond.conn_all && !cond.minor_fault && !cond.conn_timeout
    |=> led_green && !led_red; endproperty
  a_grn: assert property (p_grn) else $error("green not steady");
  property p_redfl; !hi && onl && cond.minor_fault |=> !led_green; endproperty
  a_redfl: assert property (p_redfl) else $error("green lit during fault");
  property p_st; $rose(cond.self_test) |=> led_green && !led_red; endproperty
  a_st: assert property (p_st) else $error("self test not starting green");
  property p_rd; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside its cycle");
  c_grn: cover property (led_green ##1 !led_green);
  c_red: cover property (led_red ##1 !led_red);
  c_st: cover property ($rose(cond.self_test));
endmodule : nsl_status_led_chk
bind nsl_status_led nsl_status_led_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .cond(cond),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .led_green(led_green), .led_red(led_red));

// [verification/test_nsl_status_led.sv]
// self-checking bench for the lamp sequencer
// assumes shortened tick and phase parameters, lamp model on the drives
`timescale 1ns/1ps
module test_nsl_status_led;
  localparam int TC = 4;
  localparam int FL = 5 * TC;
  localparam int STC = 3 * TC;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  nsl_pkg::nsl_cond_t cond = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic led_green;
  logic led_red;
  logic [1:0] shade;
  logic [31:0] d;
  logic [8:0] cf [2] = '{9'h092, 9'h090};
  logic [1:0] sf [2] = '{2'h1, 2'h2};
  logic [8:0] cc [4] = '{9'h09C, 9'h0D0, 9'h080, 9'h098};
  logic m;
  int miscompares = 0;
  int compares = 0;
  int n;
  always #25 core_clk = ~core_clk;
  nsl_status_led #(.TICK_CYCLES(TC), .FLASH_MS(5), .STEST_MS(3), .STEST_OFF_MS(3)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .cond(cond), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .led_green(led_green), .led_red(led_red));
  nsl_lamp_model lamp_u (.green(led_green), .red(led_red), .shade(shade));
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] w);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus
  // counts cycles until the lamp takes shade s (wait_first) or leaves it; bounded so a stuck lamp ends the run
  task automatic meas(input logic [1:0] s, input logic wait_first);
    n = 0;
    while ((shade !== s) == wait_first) begin
      @(posedge core_clk);
      #1 n++;
      if (n > 300) begin
        miscompares++;
        results();
      end
    end
  endtask : meas
  function automatic logic [5:0] xpat(input logic [8:0] c, input logic mst);
    logic on;
    on = c[7] & c[4];
    if (c[8]) return 6'h20;
    if (c[6] | c[5]) return 6'h10;
    if (mst ? on & (c[1] | c[0] | (c[3] & ~c[2])) : c[7] & (~c[3] | c[1] | c[0] | ~c[4])) return 6'h08;
    if (on & ~c[3]) return 6'h04;
    if (on & c[2]) return 6'h02;
    return 6'h01;
  endfunction : xpat
  initial begin
    d = $urandom(80119);
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk("lamp after reset", {30'h0, shade}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      cond <= cf[i];
      meas(sf[i], 1'b1);
      repeat (7) @(posedge core_clk);
      cond <= cf[1 - i];
      meas(sf[1 - i], 1'b1);
      meas(sf[1 - i], 1'b0);
      chk("flash lit", n, FL);
      meas(2'h0, 1'b0);
      chk("flash dark", n, FL);
    end
    @(posedge core_clk);
    cond <= 9'h100;
    meas(2'h2, 1'b1);
    meas(2'h2, 1'b0);
    chk("self test green", n, STC);
    meas(2'h1, 1'b0);
    chk("self test red", n, STC);
    meas(2'h0, 1'b0);
    chk("self test dark", n, STC);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    #1 chk("lamp in reset", {30'h0, shade}, 32'h0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 chk("self test after reset", {30'h0, shade}, 32'h2);
    $display("timing test done");
    for (int k = 0; k < 44; k++) begin
      m = 1'($urandom);
      bus(1'b1, 4'h0, {31'h0, m});
      d = $urandom;
      // corners first: steady green, steady red, no power, partly connected
      if (k < 4) begin
        d = {23'h0, cc[k]};
      end
      @(posedge core_clk);
      cond <= {d[8] & d[9] & d[10], d[7:0]};
      bus(1'b0, 4'h4, 32'h0);
      chk("pattern", d[5:0], xpat(cond, m));
      bus(1'b0, 4'h0, 32'h0);
      chk("role", d, {31'h0, m});
      bus(1'b0, 4'h8, 32'h0);
      chk("cond view", d, {23'h0, cond});
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", d, 32'h0);
    end
    $display("pattern test done");
    results();
  end
endmodule : test_nsl_status_led
